// ---- src/accstk_consts.svh ----
`ifndef ACCSTK_CONSTS_SVH
`define ACCSTK_CONSTS_SVH


`define ACCSTK_ACC_W        32
`define ACCSTK_WORD_W       16
`define ACCSTK_ADDR_W       16
`define ACCSTK_STACK_DEPTH  8
`define ACCSTK_OCT_DIGITS   5
`define ACCSTK_ACC_RST      32'h0000_0000
`define ACCSTK_WORD_RST     16'h0000
`define ACCSTK_ADDR_STEP    16'h0001

`endif

// ---- src/accstk_pkg.sv ----
`include "accstk_consts.svh"

package accstk_pkg;

	typedef logic [`ACCSTK_ACC_W-1:0]  accstk_acc_t;
	typedef logic [`ACCSTK_WORD_W-1:0] accstk_word_t;
	typedef logic [`ACCSTK_ADDR_W-1:0] accstk_addr_t;

	typedef enum logic [3:0]
	{
		nop_op          = 4'h0,
		load_word_op    = 4'h1,
		load_dword_op   = 4'h2,
		load_ptr_op     = 4'h3,
		load_dptr_op    = 4'h4,
		load_const_op   = 4'h5,
		load_dconst_op  = 4'h6,
		load_address_op = 4'h7,
		out_word_op     = 4'h8,
		out_dword_op    = 4'h9,
		pop_op          = 4'hA,
		result_op       = 4'hB,
		end_scan_op     = 4'hC
	} accstk_op_e;

	typedef enum logic [2:0]
	{
		st_idle   = 3'h0,
		st_ptr_rq = 3'h1,
		st_ptr_dt = 3'h3,
		st_lo_rq  = 3'h2,
		st_lo_dt  = 3'h6,
		st_hi_rq  = 3'h7,
		st_hi_dt  = 3'h5,
		st_wr_hi  = 3'h4
	} accstk_state_e;

endpackage : accstk_pkg

// ---- src/accstk_stack.sv ----
`include "accstk_consts.svh"

module accstk_stack
#(
	parameter int DEPTH = `ACCSTK_STACK_DEPTH,
	parameter int WIDTH = `ACCSTK_ACC_W
)
(
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_reset_n,
	input  wire logic                       i_push,
	input  wire logic                       i_pop,
	input  wire logic [WIDTH-1:0]           i_push_data,
	output logic      [WIDTH-1:0]           o_top,
	output logic      [$clog2(DEPTH+1)-1:0] o_level
);

	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] entry_q [DEPTH];
	logic [CW-1:0]    count_q;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_entry
			logic [WIDTH-1:0] above;
			logic [WIDTH-1:0] below;
			if (gi == 0)
			begin : g_first
				assign above = i_push_data;
			end
			else
			begin : g_rest
				assign above = entry_q[gi-1];
			end
			if (gi == DEPTH - 1)
			begin : g_last
				assign below = '0;
			end
			else
			begin : g_inner
				assign below = entry_q[gi+1];
			end
			always_ff @(posedge i_sys_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
					entry_q[gi] <= '0;
				else if (i_push)
					entry_q[gi] <= above;
				else if (i_pop)
					entry_q[gi] <= below;
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			count_q <= '0;
		else if (i_push && (count_q != CW'(DEPTH)))
			count_q <= count_q + CW'(1);
		else if (i_pop && (count_q != '0))
			count_q <= count_q - CW'(1);
	end

	assign o_top   = entry_q[0];
	assign o_level = count_q;

endmodule : accstk_stack

// ---- src/accstk_unit.sv ----
`include "accstk_consts.svh"

module accstk_unit
#(
	parameter int STACK_DEPTH = `ACCSTK_STACK_DEPTH,
	parameter int OCT_DIGITS  = `ACCSTK_OCT_DIGITS
)
(
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_op_valid,
	input  wire accstk_pkg::accstk_op_e        i_op_code,
	input  wire accstk_pkg::accstk_word_t      i_op_operand,
	input  wire accstk_pkg::accstk_word_t      i_op_const_hi,
	input  wire accstk_pkg::accstk_acc_t       i_op_result,
	input  wire accstk_pkg::accstk_word_t      i_mem_rdata,
	output logic                               o_busy,
	output logic                               o_done,
	output accstk_pkg::accstk_acc_t            o_acc,
	output logic                               o_zero_load_flag,
	output logic                               o_pending_push,
	output accstk_pkg::accstk_acc_t            o_stack_top,
	output logic [$clog2(STACK_DEPTH+1)-1:0]   o_stack_level,
	output accstk_pkg::accstk_addr_t           o_mem_addr,
	output logic                               o_mem_rd,
	output logic                               o_mem_wr,
	output accstk_pkg::accstk_word_t           o_mem_wdata
);

	import accstk_pkg::*;

	accstk_state_e state_q;
	accstk_state_e state_d;
	accstk_acc_t   acc_q;
	accstk_acc_t   acc_d;
	logic          zero_q;
	logic          zero_d;
	logic          pending_q;
	logic          pending_d;
	logic          double_q;
	logic          double_d;
	accstk_word_t  lo_q;
	accstk_word_t  lo_d;
	accstk_addr_t  addr_q;
	accstk_addr_t  addr_d;
	logic          rd_q;
	logic          rd_d;
	logic          wr_q;
	logic          wr_d;
	accstk_word_t  wdata_q;
	accstk_word_t  wdata_d;
	logic          busy_q;
	logic          done_q;
	logic          done_d;

	wire logic                idle;
	wire logic                accept;
	wire logic                is_mem_load;
	wire logic                is_ptr_load;
	wire logic                is_dbl_load;
	wire logic                is_imm_load;
	wire logic                is_out;
	wire logic                imm_load;
	wire logic                mem_lo_done;
	wire logic                mem_hi_done;
	wire logic                load_commit;
	wire logic                do_push;
	wire logic                do_pop;
	wire logic                do_result;
	wire logic                do_end_scan;
	wire logic                do_out;
	wire logic [4*OCT_DIGITS-1:0] oct_digits;
	wire logic [3*OCT_DIGITS-1:0] addr_bin;
	wire accstk_acc_t         imm_value;
	wire accstk_acc_t         mem_value;
	wire accstk_acc_t         load_value;
	wire accstk_acc_t         stack_top;
	wire logic [$clog2(STACK_DEPTH+1)-1:0] stack_level;
	wire accstk_addr_t        next_addr;

	assign idle   = (state_q == st_idle);
	assign accept = i_op_valid && idle;

	assign is_mem_load = (i_op_code == load_word_op) || (i_op_code == load_dword_op) ||
		(i_op_code == load_ptr_op) || (i_op_code == load_dptr_op);
	assign is_ptr_load = (i_op_code == load_ptr_op) || (i_op_code == load_dptr_op);
	assign is_dbl_load = (i_op_code == load_dword_op) || (i_op_code == load_dptr_op);
	assign is_imm_load = (i_op_code == load_const_op) || (i_op_code == load_dconst_op) ||
		(i_op_code == load_address_op);
	assign is_out      = (i_op_code == out_word_op) || (i_op_code == out_dword_op);

	assign imm_load    = accept && is_imm_load;
	assign mem_lo_done = (state_q == st_lo_dt) && !double_q;
	assign mem_hi_done = (state_q == st_hi_dt);
	assign load_commit = imm_load || mem_lo_done || mem_hi_done;

	assign do_push     = load_commit && pending_q;
	assign do_pop      = accept && (i_op_code == pop_op);
	assign do_result   = accept && (i_op_code == result_op);
	assign do_end_scan = accept && (i_op_code == end_scan_op);
	assign do_out      = accept && is_out;

	assign oct_digits = (4*OCT_DIGITS)'({i_op_const_hi, i_op_operand});

	genvar gd;
	generate
		for (gd = 0; gd < OCT_DIGITS; gd++)
		begin : g_oct
			assign addr_bin[3*gd+2:3*gd] = oct_digits[4*gd+2:4*gd];
		end
	endgenerate

	assign imm_value =
		(i_op_code == load_dconst_op)  ? {i_op_const_hi, i_op_operand} :
		(i_op_code == load_address_op) ? accstk_acc_t'(addr_bin) :
		{`ACCSTK_WORD_RST, i_op_operand};

	assign mem_value = mem_hi_done ? {i_mem_rdata, lo_q} :
		{`ACCSTK_WORD_RST, i_mem_rdata};

	assign load_value = imm_load ? imm_value : mem_value;
	assign next_addr  = addr_q + `ACCSTK_ADDR_STEP;

	accstk_stack
	#(
		.DEPTH (STACK_DEPTH),
		.WIDTH (`ACCSTK_ACC_W)
	)
	u_stack
	(
		.i_sys_clk   (i_sys_clk),
		.i_reset_n   (i_reset_n),
		.i_push      (do_push),
		.i_pop       (do_pop),
		.i_push_data (acc_q),
		.o_top       (stack_top),
		.o_level     (stack_level)
	);

	always_comb
	begin
		acc_d = acc_q;
		if (do_end_scan)
			acc_d = `ACCSTK_ACC_RST;
		else if (do_pop)
			acc_d = stack_top;
		else if (do_result)
			acc_d = i_op_result;
		else if (load_commit)
			acc_d = load_value;
	end

	always_comb
	begin
		zero_d = zero_q;
		if (load_commit)
			zero_d = (load_value == `ACCSTK_ACC_RST);
		else if (do_pop)
			zero_d = (stack_top == `ACCSTK_ACC_RST);
	end

	always_comb
	begin
		pending_d = pending_q;
		if (do_end_scan)
			pending_d = 1'b0;
		else if (do_out)
			pending_d = 1'b0;
		else if (load_commit)
			pending_d = 1'b1;
	end

	always_comb
	begin
		state_d  = state_q;
		double_d = double_q;
		lo_d     = lo_q;
		addr_d   = addr_q;
		rd_d     = 1'b0;
		wr_d     = 1'b0;
		wdata_d  = wdata_q;
		done_d   = 1'b0;
		case (state_q)
			st_idle:
			begin
				if (accept && is_mem_load)
				begin
					addr_d   = i_op_operand;
					rd_d     = 1'b1;
					double_d = is_dbl_load;
					state_d  = is_ptr_load ? st_ptr_rq : st_lo_rq;
				end
				else if (accept && is_out)
				begin
					addr_d  = i_op_operand;
					wr_d    = 1'b1;
					wdata_d = acc_q[`ACCSTK_WORD_W-1:0];
					if (i_op_code == out_dword_op)
						state_d = st_wr_hi;
					else
						done_d = 1'b1;
				end
				else if (accept && (i_op_code != nop_op))
					done_d = 1'b1;
			end
			st_ptr_rq:
				state_d = st_ptr_dt;
			st_ptr_dt:
			begin
				addr_d  = i_mem_rdata;
				rd_d    = 1'b1;
				state_d = st_lo_rq;
			end
			st_lo_rq:
				state_d = st_lo_dt;
			st_lo_dt:
			begin
				lo_d = i_mem_rdata;
				if (double_q)
				begin
					addr_d  = next_addr;
					rd_d    = 1'b1;
					state_d = st_hi_rq;
				end
				else
				begin
					done_d  = 1'b1;
					state_d = st_idle;
				end
			end
			st_hi_rq:
				state_d = st_hi_dt;
			st_hi_dt:
			begin
				done_d  = 1'b1;
				state_d = st_idle;
			end
			st_wr_hi:
			begin
				addr_d  = next_addr;
				wr_d    = 1'b1;
				wdata_d = acc_q[`ACCSTK_ACC_W-1:`ACCSTK_WORD_W];
				done_d  = 1'b1;
				state_d = st_idle;
			end
			default:
				state_d = st_idle;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			acc_q     <= `ACCSTK_ACC_RST;
			zero_q    <= 1'b0;
			pending_q <= 1'b0;
		end
		else
		begin
			acc_q     <= acc_d;
			zero_q    <= zero_d;
			pending_q <= pending_d;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q  <= st_idle;
			double_q <= 1'b0;
			lo_q     <= `ACCSTK_WORD_RST;
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			double_q <= double_d;
			lo_q     <= lo_d;
			busy_q   <= (state_d != st_idle);
			done_q   <= done_d;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			addr_q  <= `ACCSTK_WORD_RST;
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
			wdata_q <= `ACCSTK_WORD_RST;
		end
		else
		begin
			addr_q  <= addr_d;
			rd_q    <= rd_d;
			wr_q    <= wr_d;
			wdata_q <= wdata_d;
		end
	end

	assign o_busy           = busy_q;
	assign o_done           = done_q;
	assign o_acc            = acc_q;
	assign o_zero_load_flag = zero_q;
	assign o_pending_push   = pending_q;
	assign o_stack_top      = stack_top;
	assign o_stack_level    = stack_level;
	assign o_mem_addr       = addr_q;
	assign o_mem_rd         = rd_q;
	assign o_mem_wr         = wr_q;
	assign o_mem_wdata      = wdata_q;

endmodule : accstk_unit

// ---- verification/accstk_monitor.sv ----
module accstk_monitor
#(
	parameter int STACK_DEPTH = 8,
	parameter int OCT_DIGITS  = 5
)
(
	input wire logic                        i_sys_clk,
	input wire logic                        i_reset_n,
	input wire logic                        i_op_valid,
	input wire accstk_pkg::accstk_op_e      i_op_code,
	input wire accstk_pkg::accstk_word_t    i_op_operand,
	input wire accstk_pkg::accstk_word_t    i_op_const_hi,
	input wire accstk_pkg::accstk_acc_t     i_op_result,
	input wire accstk_pkg::accstk_word_t    i_mem_rdata,
	input wire logic                        o_busy,
	input wire logic                        o_done,
	input wire accstk_pkg::accstk_acc_t     o_acc,
	input wire logic                        o_zero_load_flag,
	input wire logic                        o_pending_push,
	input wire accstk_pkg::accstk_acc_t     o_stack_top,
	input wire logic [$clog2(STACK_DEPTH+1)-1:0] o_stack_level,
	input wire accstk_pkg::accstk_addr_t    o_mem_addr,
	input wire logic                        o_mem_rd,
	input wire logic                        o_mem_wr,
	input wire accstk_pkg::accstk_word_t    o_mem_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import accstk_pkg::*;
	wire take = i_op_valid && !o_busy;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	property p_const;
		take && i_op_code == load_const_op |=> o_acc == {16'h0000, $past(i_op_operand)};
	endproperty
	a_const: assert property (p_const) else $error("constant load wrong");
	property p_push;
		o_stack_level > $past(o_stack_level) |-> o_stack_top == $past(o_acc);
	endproperty
	a_push: assert property (p_push) else $error("push lost value");
	property p_pop;
		o_stack_level < $past(o_stack_level) |-> o_acc == $past(o_stack_top);
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong value");
	property p_depth;
		o_stack_level <= STACK_DEPTH;
	endproperty
	a_depth: assert property (p_depth) else $error("stack too deep");
	property p_zero;
		$rose(o_zero_load_flag) |-> o_acc == 32'h0000_0000;
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag on nonzero");
	property p_end;
		take && i_op_code == end_scan_op |=> o_acc == 32'h0000_0000 && !o_pending_push;
	endproperty
	a_end: assert property (p_end) else $error("scan end left data");
	property p_res;
		take && i_op_code == result_op |=> o_acc == $past(i_op_result);
	endproperty
	a_res: assert property (p_res) else $error("result not kept");
	property p_out;
		take && i_op_code == out_word_op |=> o_mem_wr && !o_pending_push
			&& o_mem_addr == $past(i_op_operand) && o_mem_wdata == o_acc[15:0];
	endproperty
	a_out: assert property (p_out) else $error("store wrong");
	property p_dbl;
		take && i_op_code == load_dword_op |=> o_mem_rd && o_mem_addr == $past(i_op_operand)
			##2 o_mem_rd && o_mem_addr == $past(i_op_operand, 3) + 16'h0001;
	endproperty
	a_dbl: assert property (p_dbl) else $error("double read order");
	property p_ptr;
		take && i_op_code == load_ptr_op |=> o_mem_rd ##2 o_mem_rd
			&& o_mem_addr == $past(i_mem_rdata);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not used");
	c_full: cover property (o_stack_level == STACK_DEPTH);
	c_pop: cover property (take && i_op_code == pop_op);
	c_dptr: cover property (take && i_op_code == load_dptr_op);
endmodule : accstk_monitor

bind accstk_unit accstk_monitor #(.STACK_DEPTH(STACK_DEPTH), .OCT_DIGITS(OCT_DIGITS)) u_mon
(
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_op_valid(i_op_valid),
	.i_op_code(i_op_code), .i_op_operand(i_op_operand), .i_op_const_hi(i_op_const_hi),
	.i_op_result(i_op_result), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done),
	.o_acc(o_acc), .o_zero_load_flag(o_zero_load_flag), .o_pending_push(o_pending_push),
	.o_stack_top(o_stack_top), .o_stack_level(o_stack_level), .o_mem_addr(o_mem_addr),
	.o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata)
);

// ---- verification/accstk_mem_model.sv ----
module accstk_mem_model
(
	input  wire logic                     i_sys_clk,
	input  wire accstk_pkg::accstk_addr_t i_mem_addr,
	input  wire logic                     i_mem_rd,
	input  wire logic                     i_mem_wr,
	input  wire accstk_pkg::accstk_word_t i_mem_wdata,
	output accstk_pkg::accstk_word_t      o_mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import accstk_pkg::*;
	accstk_word_t store [0:65535];
	initial o_mem_rdata = 16'h0000;
	// Data follows a read by one cycle; otherwise the bus toggles so stale data is never valid.
	always @(posedge i_sys_clk)
	begin
		if (i_mem_wr)
			store[i_mem_addr] <= i_mem_wdata;
		o_mem_rdata <= i_mem_rd ? store[i_mem_addr] : ~o_mem_rdata;
	end
endmodule : accstk_mem_model

// ---- verification/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import accstk_pkg::*;
	logic         sys_clk = 0, reset_n = 0, valid = 0, busy, done, zflag, pend, rd, wr;
	accstk_op_e   code = nop_op;
	accstk_word_t opnd = 16'h0000, hi = 16'h0000, rdata, wdata;
	accstk_acc_t  res = 32'h0000_0000, acc, top;
	accstk_addr_t addr;
	logic [3:0]   level;
	int           error_cnt = 0, samples_checked = 0;
	always #4 sys_clk = ~sys_clk;
	accstk_unit dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_op_valid(valid),
		.i_op_code(code), .i_op_operand(opnd), .i_op_const_hi(hi), .i_op_result(res),
		.i_mem_rdata(rdata), .o_busy(busy), .o_done(done), .o_acc(acc),
		.o_zero_load_flag(zflag), .o_pending_push(pend), .o_stack_top(top),
		.o_stack_level(level), .o_mem_addr(addr), .o_mem_rd(rd), .o_mem_wr(wr),
		.o_mem_wdata(wdata));
	accstk_mem_model mem (.i_sys_clk(sys_clk), .i_mem_addr(addr), .i_mem_rd(rd),
		.i_mem_wr(wr), .i_mem_wdata(wdata), .o_mem_rdata(rdata));
	task automatic complete_run;
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic chk(input accstk_acc_t got, input accstk_acc_t exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Issues one operation and waits, bounded, for its completion pulse.
	task automatic op(input accstk_op_e c, input accstk_word_t a,
		input accstk_word_t h = 16'h0000, input accstk_acc_t r = 32'h0000_0000);
		int n;
		n = 0;
		@(posedge sys_clk);
		valid <= 1'b1;
		code <= c;
		opnd <= a;
		hi <= h;
		res <= r;
		@(posedge sys_clk);
		valid <= 1'b0;
		@(negedge sys_clk);
		while (done !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				error_cnt++;
				complete_run();
			end
			@(negedge sys_clk);
		end
	endtask : op
	task automatic t_push_order;
		op(load_word_op, 16'h0300);
		chk(acc, 32'h0000_1234);
		chk(32'(level), 32'h0000_0000);
		op(load_const_op, 16'h0000);
		chk(top, 32'h0000_1234);
		chk(32'(zflag), 32'h0000_0001);
		op(out_word_op, 16'h0310);
		chk(32'(pend), 32'h0000_0000);
		op(load_const_op, 16'h0005);
		chk(32'(level), 32'h0000_0001);
		chk(32'(mem.store[16'h0310]), 32'h0000_0000);
	endtask : t_push_order
	task automatic t_double;
		op(load_dword_op, 16'h0320);
		chk(acc, 32'h00C0_BEEF);
		op(result_op, 16'h0000, 16'h0000, 32'h8765_4321);
		chk(acc, 32'h8765_4321);
		op(out_dword_op, 16'h0330);
		op(end_scan_op, 16'h0000);
		chk(acc, 32'h0000_0000);
		chk({mem.store[16'h0331], mem.store[16'h0330]}, 32'h8765_4321);
	endtask : t_double
	task automatic t_pointer;
		op(load_address_op, 16'h2345, 16'h0001);
		chk(acc, 32'h0000_14E5);
		op(load_address_op, 16'h2000);
		chk(acc, 32'h0000_0400);
		op(out_word_op, 16'h0340);
		op(end_scan_op, 16'h0000);
		op(load_ptr_op, 16'h0340);
		chk(acc, 32'h0000_5A5A);
		op(load_dptr_op, 16'h0340);
		chk(acc, 32'h0F0F_5A5A);
		chk(top, 32'h0000_5A5A);
	endtask : t_pointer
	task automatic t_overflow;
		op(end_scan_op, 16'h0000);
		for (int i = 1; i <= 10; i++)
			op(load_const_op, 16'(i));
		chk(32'(level), 32'h0000_0008);
		for (int i = 0; i < 8; i++)
		begin
			op(pop_op, 16'h0000);
			chk(acc, 32'(9 - i));
			chk(32'(level), 32'(7 - i));
		end
		op(pop_op, 16'h0000);
		chk(acc, 32'h0000_0000);
		chk(32'(zflag), 32'h0000_0001);
	endtask : t_overflow
	initial
	begin
		mem.store[16'h0300] = 16'h1234;
		mem.store[16'h0320] = 16'hBEEF;
		mem.store[16'h0321] = 16'h00C0;
		mem.store[16'h0400] = 16'h5A5A;
		mem.store[16'h0401] = 16'h0F0F;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_push_order();
		t_double();
		t_pointer();
		t_overflow();
		complete_run();
	end
endmodule : tb
